// ---- common/fairness_consts.svh ----
// constants for the fairness advertisement and byte statistics block
`ifndef FAIRNESS_CONSTS_SVH
`define FAIRNESS_CONSTS_SVH
`define FULL_RATE_VALUE    16'hffff
`define SOURCE_HOP_LIMIT   8'hff
`define SINGLE_CHOKE_TYPE  3'h0
`define MULTI_CHOKE_TYPE   3'h1
`define MULTI_CHOKE_EVERY  4'ha
`define RESERVED_FILL      13'h0000
`define COUNT_WIDTH        32
`endif

// ---- common/fairness_pkg.sv ----
// types for the fairness advertisement and byte statistics block
package fairness_pkg;
   typedef struct packed {
      logic [2:0]  choke_message_type;
      logic [12:0] reserved;
      logic [15:0] advertised_rate_field;
      logic [47:0] source_address;
      logic [7:0]  hop_limit;
      logic        ringlet_id;
   } choke_msg_t;

   typedef struct packed {
      logic eligible_byte_added;
      logic eligible_byte_forwarded;
      logic add_beyond_choke_point;
      logic fwd_beyond_choke_point;
      logic add_non_reserved_class;
      logic fwd_non_reserved_class;
   } byte_events_t;
endpackage : fairness_pkg

// ---- rtl/fairness_advertise.sv ----
// fairness message generation, per-byte counters and data path rate outputs
`timescale 1ns/100ps
`include "fairness_consts.svh"
module fairness_advertise
   import fairness_pkg::*;
#(
   parameter int CW = `COUNT_WIDTH
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         advert_period,
   input  wire logic         own_station_congested,
   input  wire logic         downstream_congested_flag,
   input  wire logic [15:0]  normalized_own_fair_rate,
   input  wire logic [15:0]  received_advertised_rate,
   input  wire logic [15:0]  normalized_filtered_cong_forward_rate,
   input  wire logic [47:0]  own_source_address,
   input  wire logic [47:0]  received_source_address,
   input  wire logic [7:0]   received_hop_limit,
   input  wire logic         received_ringlet_id,
   input  wire logic         own_ringlet_id,
   input  wire logic         received_single_choke,
   input  wire logic [15:0]  allowed_rate_in,
   input  wire byte_events_t byte_events,
   output choke_msg_t        single_msg,
   output logic              single_msg_valid,
   output choke_msg_t        multi_msg,
   output logic              multi_msg_valid,
   output logic [CW-1:0]     added_byte_count,
   output logic [CW-1:0]     added_beyond_choke_count,
   output logic [CW-1:0]     forwarded_byte_count,
   output logic [CW-1:0]     forwarded_beyond_choke_count,
   output logic [CW-1:0]     non_reserved_tx_count,
   output logic [15:0]       permitted_add_rate,
   output logic [15:0]       permitted_choke_rate,
   output logic [7:0]        hops_to_choke_point
);
   // counters narrower than a byte wrap too fast to be read usefully
   if (CW < 8 || CW > 64) begin : g_bad_width
      $error("count width out of range");
   end

   logic [3:0]  interval_cnt_reg;
   choke_msg_t  single_next;
   choke_msg_t  local_msg;
   logic        multi_due;

   assign multi_due = (interval_cnt_reg == `MULTI_CHOKE_EVERY - 4'h1);

   // self-originated message template; reserved bits zero
   always_comb begin
      local_msg.choke_message_type    = `SINGLE_CHOKE_TYPE;
      local_msg.reserved              = `RESERVED_FILL;
      local_msg.advertised_rate_field = `FULL_RATE_VALUE;
      local_msg.source_address        = own_source_address;
      local_msg.hop_limit             = `SOURCE_HOP_LIMIT;
      local_msg.ringlet_id            = own_ringlet_id;
   end

   // rows tested in order, first match wins
   always_comb begin
      single_next = local_msg;
      if (own_station_congested && (!downstream_congested_flag ||
          normalized_own_fair_rate < received_advertised_rate)) begin
         single_next.advertised_rate_field = normalized_own_fair_rate;
      end else if (downstream_congested_flag && (!own_station_congested ||
                   normalized_own_fair_rate > received_advertised_rate)) begin
         if (received_advertised_rate < normalized_filtered_cong_forward_rate) begin
            single_next.advertised_rate_field = received_advertised_rate;
            single_next.source_address        = received_source_address;
            single_next.hop_limit             = received_hop_limit;
            single_next.ringlet_id            = received_ringlet_id;
         end
         // else full rate from template
      end
      // both congested with equal rates falls to full rate too
   end

   // interval count for multi-choke cadence
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         interval_cnt_reg <= 4'h0;
      end else if (advert_period) begin
         interval_cnt_reg <= multi_due ? 4'h0 : interval_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         single_msg       <= '0;
         single_msg_valid <= 1'b0;
      end else begin
         single_msg_valid <= advert_period;
         if (advert_period) begin
            single_msg <= single_next;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         multi_msg       <= '0;
         multi_msg_valid <= 1'b0;
      end else begin
         multi_msg_valid <= advert_period && multi_due;
         if (advert_period && multi_due) begin
            multi_msg                    <= local_msg;
            multi_msg.choke_message_type <= `MULTI_CHOKE_TYPE;
            multi_msg.advertised_rate_field <= own_station_congested ?
               normalized_own_fair_rate : `FULL_RATE_VALUE;
         end
      end
   end

   // byte inputs come from data path logic on this clock
   wire add_ev = byte_events.eligible_byte_added;
   wire fwd_ev = byte_events.eligible_byte_forwarded;
   wire [1:0] nr_inc = {1'b0, add_ev && byte_events.add_non_reserved_class}
                     + {1'b0, fwd_ev && byte_events.fwd_non_reserved_class};

   // counters wrap; aging lives elsewhere
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         added_byte_count             <= '0;
         added_beyond_choke_count     <= '0;
         forwarded_byte_count         <= '0;
         forwarded_beyond_choke_count <= '0;
         non_reserved_tx_count        <= '0;
      end else begin
         if (add_ev) added_byte_count <= added_byte_count + 1'b1;
         if (add_ev && byte_events.add_beyond_choke_point)
            added_beyond_choke_count <= added_beyond_choke_count + 1'b1;
         if (fwd_ev) forwarded_byte_count <= forwarded_byte_count + 1'b1;
         if (fwd_ev && byte_events.fwd_beyond_choke_point)
            forwarded_beyond_choke_count <= forwarded_beyond_choke_count + 1'b1;
         non_reserved_tx_count <= non_reserved_tx_count + CW'(nr_inc);
      end
   end

   // rate outputs to shapers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         permitted_add_rate   <= `FULL_RATE_VALUE;
         permitted_choke_rate <= `FULL_RATE_VALUE;
         hops_to_choke_point  <= 8'h00;
      end else begin
         permitted_add_rate <= allowed_rate_in;
         if (received_single_choke) begin
            permitted_choke_rate <= received_advertised_rate;
            hops_to_choke_point  <= 8'h00 - received_hop_limit;
         end
      end
   end

   property p_no_cong_full;
      @(posedge sys_clk) disable iff (!resetn)
      advert_period && !own_station_congested && !downstream_congested_flag
      |=> single_msg_valid && single_msg.advertised_rate_field == 16'hffff
          && single_msg.hop_limit == 8'hff;
   endproperty
   a_no_cong_full: assert property (p_no_cong_full)
      else $error("no-congestion msg wrong");

   property p_local_rate;
      @(posedge sys_clk) disable iff (!resetn)
      advert_period && own_station_congested && !downstream_congested_flag
      |=> single_msg.advertised_rate_field == $past(normalized_own_fair_rate)
          && single_msg.source_address == $past(own_source_address);
   endproperty
   a_local_rate: assert property (p_local_rate)
      else $error("local rate msg wrong");

   property p_relay;
      @(posedge sys_clk) disable iff (!resetn)
      advert_period && downstream_congested_flag && !own_station_congested
      && received_advertised_rate < normalized_filtered_cong_forward_rate
      |=> single_msg.hop_limit == $past(received_hop_limit)
          && single_msg.source_address == $past(received_source_address);
   endproperty
   a_relay: assert property (p_relay)
      else $error("relay msg wrong");

   property p_multi_type;
      @(posedge sys_clk) disable iff (!resetn)
      multi_msg_valid |-> multi_msg.choke_message_type == 3'h1 && multi_msg.reserved == 13'h0;
   endproperty
   a_multi_type: assert property (p_multi_type)
      else $error("multi msg type wrong");

   property p_single_reserved;
      @(posedge sys_clk) disable iff (!resetn)
      single_msg_valid |-> single_msg.reserved == 13'h0 && single_msg.choke_message_type == 3'h0;
   endproperty
   a_single_reserved: assert property (p_single_reserved)
      else $error("reserved not zero");

   property p_add_count;
      @(posedge sys_clk) disable iff (!resetn)
      add_ev |=> added_byte_count == $past(added_byte_count) + 1'b1;
   endproperty
   a_add_count: assert property (p_add_count)
      else $error("add counter missed");

   property p_fwd_count;
      @(posedge sys_clk) disable iff (!resetn)
      !fwd_ev |=> forwarded_byte_count == $past(forwarded_byte_count);
   endproperty
   a_fwd_count: assert property (p_fwd_count)
      else $error("forward counter moved");

   property p_both_nr;
      @(posedge sys_clk) disable iff (!resetn)
      add_ev && fwd_ev && byte_events.add_non_reserved_class
      && byte_events.fwd_non_reserved_class
      |=> non_reserved_tx_count == $past(non_reserved_tx_count) + 2'd2;
   endproperty
   a_both_nr: assert property (p_both_nr)
      else $error("same-cycle bytes lost");

   property p_choke_rate;
      @(posedge sys_clk) disable iff (!resetn)
      received_single_choke |=> permitted_choke_rate == $past(received_advertised_rate);
   endproperty
   a_choke_rate: assert property (p_choke_rate)
      else $error("choke rate not taken");

   property p_hops;
      @(posedge sys_clk) disable iff (!resetn)
      received_single_choke |=> hops_to_choke_point == 8'h00 - $past(received_hop_limit);
   endproperty
   a_hops: assert property (p_hops)
      else $error("hop count not taken");

   property p_add_rate;
      @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> permitted_add_rate == $past(allowed_rate_in);
   endproperty
   a_add_rate: assert property (p_add_rate)
      else $error("permitted rate not copied");
endmodule : fairness_advertise

// ---- test/datapath_model.sv ----
// data path model: paces added bytes against the permitted rate, supplies byte indications
`timescale 1ns/100ps
module datapath_model
   import fairness_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [15:0]  permitted_add_rate,
   input  wire byte_events_t byte_request,
   output byte_events_t      byte_events
);
   logic [16:0] credit_reg;
   logic        add_ok;
   // one byte costs 2^16 credit; idle credit is held, not banked further, so no bursts
   assign add_ok = credit_reg[16];
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         credit_reg <= 17'h00000;
      end else if (!add_ok || byte_request.eligible_byte_added) begin
         credit_reg <= {1'b0, credit_reg[15:0]} + {1'b0, permitted_add_rate};
      end
   end
   always_comb begin
      byte_events = byte_request;
      if (!add_ok) begin
         byte_events.eligible_byte_added    = 1'b0;
         byte_events.add_beyond_choke_point = 1'b0;
         byte_events.add_non_reserved_class = 1'b0;
      end
   end
endmodule : datapath_model

// ---- test/fairness_advertise_bench.sv ----
// self-checking bench for the fairness advertisement and byte statistics block
`timescale 1ns/100ps
`include "fairness_consts.svh"
module fairness_advertise_bench;
   import fairness_pkg::*;
   localparam int          CW  = 16;
   localparam logic [47:0] OSA = 48'h0a0b0c0d0e0f;
   localparam logic [47:0] RSA = 48'h112233445566;
   localparam logic [2:0]  SC  = `SINGLE_CHOKE_TYPE;
   localparam logic [15:0] FR  = `FULL_RATE_VALUE;
   logic          sys_clk, resetn, advert_period, oc_i, dc_i, rx_choke;
   logic [15:0]   own_r, rx_r, filt_r, allow_in, p_add, p_choke;
   logic [7:0]    hops;
   byte_events_t  byte_request, dp_ev;
   choke_msg_t    single_msg, multi_msg;
   logic          s_val, m_val;
   logic [CW-1:0] c_add, c_addb, c_fwd, c_fwdb, c_nr, e_add, e_addb, e_fwd, e_fwdb, e_nr;
   int            fails, num_checks, n_adv;

   fairness_advertise #(.CW(CW)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
      .advert_period(advert_period), .own_station_congested(oc_i),
      .downstream_congested_flag(dc_i), .normalized_own_fair_rate(own_r),
      .received_advertised_rate(rx_r), .normalized_filtered_cong_forward_rate(filt_r),
      .own_source_address(OSA), .received_source_address(RSA),
      .received_hop_limit(8'h3c), .received_ringlet_id(1'b0), .own_ringlet_id(1'b1),
      .received_single_choke(rx_choke), .allowed_rate_in(allow_in), .byte_events(dp_ev),
      .single_msg(single_msg), .single_msg_valid(s_val), .multi_msg(multi_msg),
      .multi_msg_valid(m_val), .added_byte_count(c_add), .added_beyond_choke_count(c_addb),
      .forwarded_byte_count(c_fwd), .forwarded_beyond_choke_count(c_fwdb),
      .non_reserved_tx_count(c_nr), .permitted_add_rate(p_add),
      .permitted_choke_rate(p_choke), .hops_to_choke_point(hops));
   datapath_model model_u (.sys_clk(sys_clk), .resetn(resetn), .permitted_add_rate(p_add),
      .byte_request(byte_request), .byte_events(dp_ev));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [191:0] got, input logic [191:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic choke_msg_t mk(logic [2:0] t, logic [15:0] r, logic rel);
      if (rel) mk = '{t, `RESERVED_FILL, r, RSA, 8'h3c, 1'b0};
      else mk = '{t, `RESERVED_FILL, r, OSA, `SOURCE_HOP_LIMIT, 1'b1};
   endfunction : mk

   task automatic adv(input logic oc, input logic dc, input logic [15:0] own,
                      input logic [15:0] rx, input choke_msg_t es);
      oc_i          = oc;
      dc_i          = dc;
      own_r         = own;
      rx_r          = rx;
      advert_period = 1'b1;
      @(negedge sys_clk);
      advert_period = 1'b0;
      n_adv++;
      chk({s_val, single_msg}, {1'b1, es});
      chk(m_val, n_adv % 10 == 0);
      if (n_adv % 10 == 0) begin
         chk(multi_msg, mk(`MULTI_CHOKE_TYPE, oc ? own : FR, 1'b0));
      end
      @(negedge sys_clk);
      chk({s_val, m_val}, 2'h0);
   endtask : adv

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (2000) @(posedge sys_clk);
      fails++;
      summarize();
   end

   initial begin
      {resetn, advert_period, oc_i, dc_i, rx_choke, own_r, rx_r} = '0;
      {filt_r, allow_in, byte_request, n_adv, fails, num_checks} = {16'h5000, 16'hffff, 6'h00, 96'h0};
      {e_add, e_addb, e_fwd, e_fwdb, e_nr} = '0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      chk({s_val, m_val, single_msg, multi_msg}, '0);
      chk({c_add, c_addb, c_fwd, c_fwdb, c_nr, p_add, p_choke, hops}, {80'h0, 40'hffffffff00});
      adv(1'b1, 1'b0, 16'h1234, 16'h9000, mk(SC, 16'h1234, 1'b0));
      adv(1'b1, 1'b1, 16'h1000, 16'h2000, mk(SC, 16'h1000, 1'b0));
      adv(1'b1, 1'b1, 16'h3000, 16'h2000, mk(SC, 16'h2000, 1'b1));
      adv(1'b0, 1'b1, 16'h3000, 16'h2000, mk(SC, 16'h2000, 1'b1));
      adv(1'b0, 1'b1, 16'h3000, 16'h5000, mk(SC, FR, 1'b0));
      adv(1'b0, 1'b0, 16'h3000, 16'h2000, mk(SC, FR, 1'b0));
      adv(1'b1, 1'b1, 16'h2000, 16'h2000, mk(SC, FR, 1'b0));
      for (int i = 0; i < 13; i++) begin
         if (i == 2) begin
            adv(1'b1, 1'b0, 16'h0777, 16'h9000, mk(SC, 16'h0777, 1'b0));
         end else begin
            adv(1'b0, 1'b0, 16'h0777, 16'h9000, mk(SC, FR, 1'b0));
         end
      end
      rx_r     = 16'h4321;
      rx_choke = 1'b1;
      allow_in = 16'h8000;
      @(negedge sys_clk);
      rx_choke = 1'b0;
      rx_r     = 16'h0100;
      @(negedge sys_clk);
      chk({p_choke, hops, p_add}, {16'h4321, 8'hc4, 16'h8000});
      // every qualifier mix, back to back; the model withholds adds when credit is short
      for (int i = 0; i < 64; i++) begin
         byte_request = byte_events_t'(i[5:0]);
         #1;
         e_add  += CW'(dp_ev.eligible_byte_added);
         e_addb += CW'(dp_ev.eligible_byte_added & dp_ev.add_beyond_choke_point);
         e_fwd  += CW'(dp_ev.eligible_byte_forwarded);
         e_fwdb += CW'(dp_ev.eligible_byte_forwarded & dp_ev.fwd_beyond_choke_point);
         e_nr   += CW'(dp_ev.eligible_byte_added & dp_ev.add_non_reserved_class)
                 + CW'(dp_ev.eligible_byte_forwarded & dp_ev.fwd_non_reserved_class);
         @(negedge sys_clk);
         chk({c_add, c_addb, c_fwd, c_fwdb, c_nr},
             {e_add, e_addb, e_fwd, e_fwdb, e_nr});
      end
      summarize();
   end
endmodule : fairness_advertise_bench
